// File: core/ssi_host.sv
/*
 * Two-wire bus master for the metering device: holds the shared select pin
 * high, locks the two-wire port after reset, then runs register writes and
 * two-stage reads. Assumes external pull-ups and an open-drain pad outside.
 */
`timescale 1ns/1ps
module ssi_host #(
    parameter int          QTR      = ssi_pkg::QTR_CYC,
    parameter logic [15:0] LOCK_REG = ssi_pkg::LOCK_REG_ADDR
) (
    input  wire logic             ref_clk,    // 10 MHz system clock
    input  wire logic             rst,        // async reset, active high
    input  wire logic             cmd_valid,  // command offered
    output logic                  cmd_ready,  // command can be taken
    input  wire ssi_pkg::ssi_cmd_s cmd,       // command fields
    output logic                  rsp_valid,  // one-cycle answer strobe
    output ssi_pkg::ssi_rsp_s     rsp,        // answer fields
    output logic                  locked,     // two-wire port locked
    output logic                  shared_select_pin, // select pin level
    input  wire logic             scl_lvl,    // bus clock line level
    output logic                  scl_drv,    // bus clock drive value
    output logic                  scl_oe,     // bus clock pulled low
    input  wire logic             sda_lvl,    // bus data line level
    output logic                  sda_drv,    // bus data drive value
    output logic                  sda_oe      // bus data pulled low
);
    localparam int             QW    = $clog2(QTR + 1);
    localparam logic [QW-1:0]  QLOAD = QW'(QTR - 1);

    ssi_pkg::ssi_state_e st_q, st_d;
    ssi_pkg::ssi_role_e  role_q, role_d;
    logic [1:0]    ph_q, ph_d;
    logic [QW-1:0] tq_q, tq_d;
    logic [3:0]    bit_q, bit_d;
    logic [7:0]    sh_q, sh_d;
    logic [31:0]   rx_q, rx_d, wd_q, wd_d;
    logic [15:0]   addr_q, addr_d;
    logic [2:0]    cnt_q, cnt_d, n_q, n_d;
    logic          rd_q, rd_d, rdst_q, rdst_d, int_q, int_d;
    logic          ackbad_q, ackbad_d, nack_q, nack_d, lost_q, lost_d;
    logic          scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic          pend_q, pend_d, locked_q, locked_d;
    logic          rdy_q, rdy_d, rsp_v_q, rsp_v_d, sel_q;
    logic [1:0]    lines_s;
    logic          scl_s, sda_s;

    ssi_sync2 #(.W(2)) u_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({scl_lvl, sda_lvl}),
        .q   (lines_s)
    );
    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];

    // byte k-1 counted from the bottom, so the top byte goes first
    function automatic logic [7:0] pick_byte(input logic [31:0] d, input logic [2:0] k);
        logic [31:0] s;
        s = d >> {k - 3'd1, 3'b000};
        return s[7:0];
    endfunction : pick_byte

    // data line pull for a bit slot: tx bit, our ack on reads, or release
    function automatic logic drive_for(input ssi_pkg::ssi_role_e r, input logic [3:0] b,
                                       input logic [7:0] s, input logic [2:0] c);
        if (r == ssi_pkg::RL_RDAT)
            return (b == 4'h8) && (c != 3'h1);
        return (b == 4'h8) ? 1'b0 : ~s[7];
    endfunction : drive_for

    wire tick  = (tq_q == '0);
    wire stall = !scl_oe_q && !scl_s;   // released clock held low elsewhere
    wire step  = tick && !stall;
    wire tx    = (role_q != ssi_pkg::RL_RDAT);
    wire last  = (cnt_q == 3'h1);
    wire take  = (st_q == ssi_pkg::ST_IDLE) && !pend_q && cmd_valid && rdy_q;
    wire go    = (st_q == ssi_pkg::ST_IDLE) && (pend_q || take);
    wire [2:0] cmd_n = (cmd.nbytes == 3'h0) ? 3'h1 : cmd.nbytes;

    always_comb begin
        st_d = st_q; role_d = role_q; ph_d = ph_q; bit_d = bit_q; sh_d = sh_q;
        rx_d = rx_q; wd_d = wd_q; addr_d = addr_q; cnt_d = cnt_q; n_d = n_q;
        rd_d = rd_q; rdst_d = rdst_q; int_d = int_q; ackbad_d = ackbad_q;
        nack_d = nack_q; lost_d = lost_q; scl_oe_d = scl_oe_q; sda_oe_d = sda_oe_q;
        pend_d = pend_q; locked_d = locked_q; rsp_v_d = 1'b0;
        tq_d = (st_q == ssi_pkg::ST_IDLE || st_q == ssi_pkg::ST_DONE || step) ? QLOAD
             : (stall ? tq_q : tq_q - QW'(1));
        unique case (st_q)
            ssi_pkg::ST_IDLE: begin
                if (go) begin
                    int_d  = pend_q;
                    rd_d   = pend_q ? 1'b0 : cmd.rd;
                    addr_d = pend_q ? LOCK_REG : cmd.addr;
                    wd_d   = pend_q ? {24'h0, ssi_pkg::LOCK_VALUE} : cmd.wdata;
                    n_d    = pend_q ? 3'h1 : cmd_n;
                    st_d = ssi_pkg::ST_START; ph_d = 2'd0; rdst_d = 1'b0;
                    role_d = ssi_pkg::RL_ADDR; bit_d = 4'h0;
                    sh_d = {ssi_pkg::SLAVE_ADDR, 1'b0};
                    rx_d = '0; ackbad_d = 1'b0; nack_d = 1'b0; lost_d = 1'b0;
                    scl_oe_d = 1'b0; sda_oe_d = 1'b0;
                end
            end
            ssi_pkg::ST_START: if (step) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) sda_oe_d = 1'b1;
                if (ph_q == 2'd1) scl_oe_d = 1'b1;
                if (ph_q == 2'd2) begin
                    st_d = ssi_pkg::ST_BIT; ph_d = 2'd0;
                    sda_oe_d = drive_for(role_q, bit_q, sh_q, cnt_q);
                end
            end
            ssi_pkg::ST_RSTART: if (step) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) scl_oe_d = 1'b0;
                if (ph_q == 2'd1) sda_oe_d = 1'b1;
                if (ph_q == 2'd2) scl_oe_d = 1'b1;
                if (ph_q == 2'd3) begin
                    st_d = ssi_pkg::ST_BIT; ph_d = 2'd0; rdst_d = 1'b1;
                    role_d = ssi_pkg::RL_ADDR; bit_d = 4'h0;
                    sh_d = {ssi_pkg::SLAVE_ADDR, 1'b1};
                    sda_oe_d = ~sh_d[7];
                end
            end
            ssi_pkg::ST_BIT: if (step) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) scl_oe_d = 1'b0;
                if (ph_q == 2'd2) scl_oe_d = 1'b1;
                if (ph_q == 2'd1) begin
                    if (bit_q != 4'h8 && tx && sh_q[7] && !sda_s) begin
                        // another master won the line: back off at once
                        lost_d = 1'b1; st_d = ssi_pkg::ST_DONE;
                        scl_oe_d = 1'b0; sda_oe_d = 1'b0;
                    end
                    if (bit_q == 4'h8 && tx) ackbad_d = sda_s;
                    if (bit_q != 4'h8 && !tx) rx_d = {rx_q[30:0], sda_s};
                end
                if (ph_q == 2'd3) begin
                    ph_d = 2'd0;
                    if (bit_q != 4'h8) begin
                        bit_d = bit_q + 4'h1;
                        if (tx) sh_d = {sh_q[6:0], 1'b0};
                    end else begin
                        bit_d = 4'h0;
                        if (tx && ackbad_q) begin
                            nack_d = 1'b1; st_d = ssi_pkg::ST_STOP;
                        end else begin
                            unique case (role_q)
                                ssi_pkg::RL_ADDR: begin
                                    role_d = rdst_q ? ssi_pkg::RL_RDAT : ssi_pkg::RL_REG;
                                    cnt_d  = rdst_q ? n_q : 3'h2;
                                    sh_d   = pick_byte({16'h0, addr_q}, 3'h2);
                                end
                                ssi_pkg::RL_REG: begin
                                    if (!last) begin
                                        cnt_d = 3'h1;
                                        sh_d  = pick_byte({16'h0, addr_q}, 3'h1);
                                    end else if (rd_q) begin
                                        st_d = ssi_pkg::ST_RSTART;
                                    end else begin
                                        role_d = ssi_pkg::RL_WDAT; cnt_d = n_q;
                                        sh_d   = pick_byte(wd_q, n_q);
                                    end
                                end
                                default: begin
                                    if (last) begin
                                        st_d = ssi_pkg::ST_STOP;
                                    end else begin
                                        cnt_d = cnt_q - 3'h1;
                                        sh_d  = pick_byte(wd_q, cnt_q - 3'h1);
                                    end
                                end
                            endcase
                        end
                    end
                    if (st_d == ssi_pkg::ST_BIT)
                        sda_oe_d = drive_for(role_d, bit_d, sh_d, cnt_d);
                    else
                        sda_oe_d = (st_d == ssi_pkg::ST_STOP);
                end
            end
            ssi_pkg::ST_STOP: if (step) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) scl_oe_d = 1'b0;
                if (ph_q == 2'd1) sda_oe_d = 1'b0;
                if (ph_q == 2'd2) st_d = ssi_pkg::ST_DONE;
            end
            ssi_pkg::ST_DONE: begin
                st_d = ssi_pkg::ST_IDLE;
                rsp_v_d = !int_q;
                // a failed lock write is simply retried from idle
                if (int_q && !nack_q && !lost_q) begin
                    locked_d = 1'b1; pend_d = 1'b0;
                end
            end
            default: st_d = ssi_pkg::ST_IDLE;
        endcase
        rdy_d = (st_d == ssi_pkg::ST_IDLE) && !take && !go && locked_d && !pend_d;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= ssi_pkg::ST_IDLE; role_q <= ssi_pkg::RL_ADDR; ph_q <= 2'd0;
            tq_q <= '0; bit_q <= 4'h0; sh_q <= 8'h00; rx_q <= 32'h0; wd_q <= 32'h0;
            addr_q <= 16'h0; cnt_q <= 3'h0; n_q <= 3'h1; rd_q <= 1'b0; rdst_q <= 1'b0;
            int_q <= 1'b0; ackbad_q <= 1'b0; nack_q <= 1'b0; lost_q <= 1'b0;
            scl_oe_q <= 1'b0; sda_oe_q <= 1'b0; pend_q <= 1'b1; locked_q <= 1'b0;
            rdy_q <= 1'b0; rsp_v_q <= 1'b0; sel_q <= 1'b1;
        end else begin
            st_q <= st_d; role_q <= role_d; ph_q <= ph_d; tq_q <= tq_d; bit_q <= bit_d;
            sh_q <= sh_d; rx_q <= rx_d; wd_q <= wd_d; addr_q <= addr_d; cnt_q <= cnt_d;
            n_q <= n_d; rd_q <= rd_d; rdst_q <= rdst_d; int_q <= int_d;
            ackbad_q <= ackbad_d; nack_q <= nack_d; lost_q <= lost_d;
            scl_oe_q <= scl_oe_d; sda_oe_q <= sda_oe_d; pend_q <= pend_d;
            locked_q <= locked_d; rdy_q <= rdy_d; rsp_v_q <= rsp_v_d;
            sel_q <= 1'b1;   // never toggled: device stays on two-wire
        end
    end

    assign cmd_ready = rdy_q;
    assign rsp_valid = rsp_v_q;
    assign rsp       = '{rdata: rx_q, nack: nack_q, lost: lost_q};
    assign locked    = locked_q;
    assign shared_select_pin = sel_q;
    assign scl_oe    = scl_oe_q;
    assign sda_oe    = sda_oe_q;
    assign scl_drv   = 1'b0;   // open drain: only ever pulls low
    assign sda_drv   = 1'b0;

    property p_sel_high;
        @(posedge ref_clk) disable iff (rst)
            $past(sel_q) |-> shared_select_pin && !$fell(shared_select_pin);
    endproperty
    a_sel_high: assert property (p_sel_high) else $error("select pin left high level");

    property p_first_byte;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_BIT && $past(st_q) == ssi_pkg::ST_START)
            |-> sh_q == {ssi_pkg::SLAVE_ADDR, 1'b0} && role_q == ssi_pkg::RL_ADDR;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("first byte not write address");

    property p_read_addr;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_BIT && $past(st_q) == ssi_pkg::ST_RSTART)
            |-> sh_q == {ssi_pkg::SLAVE_ADDR, 1'b1} && rdst_q;
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("read stage address wrong");

    property p_scl_high;
        @(posedge ref_clk) disable iff (rst) $fell(scl_oe_q) |-> !scl_oe_q [*7];
    endproperty
    a_scl_high: assert property (p_scl_high) else $error("bus clock high phase too short");

    property p_msb_first;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_BIT && ph_q == 2'd3 && step && bit_q < 4'h8 && tx)
            |=> sh_q == {$past(sh_q[6:0]), 1'b0} && bit_q == $past(bit_q) + 4'h1;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("byte not shifted msb first");

    property p_nack_last;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_BIT && role_q == ssi_pkg::RL_RDAT && bit_q == 4'h8 && ph_q == 2'd1)
            |-> sda_oe_q == (cnt_q != 3'h1);
    endproperty
    a_nack_last: assert property (p_nack_last) else $error("read ack level wrong");

    property p_stop_after;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_BIT && role_q == ssi_pkg::RL_WDAT && bit_q == 4'h8
             && ph_q == 2'd3 && step && last)
            |=> st_q == ssi_pkg::ST_STOP ##1 sda_oe_q && scl_oe_q;
    endproperty
    a_stop_after: assert property (p_stop_after) else $error("no stop after last byte");

    property p_lock_write;
        @(posedge ref_clk) disable iff (rst)
            $rose(locked_q) |-> $past(int_q) && addr_q == LOCK_REG
                && wd_q[ssi_pkg::LOCK_BIT] && !$past(nack_q);
    endproperty
    a_lock_write: assert property (p_lock_write) else $error("lock set without lock write");

    property p_start_cond;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_START && ph_q == 2'd1) |-> sda_oe_q && !scl_oe_q;
    endproperty
    a_start_cond: assert property (p_start_cond) else $error("start without clock high");

    property p_scl_low;
        @(posedge ref_clk) disable iff (rst) $rose(scl_oe_q) |-> scl_oe_q [*7];
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("bus clock low phase too short");

    property p_no_wr_rstart;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_RSTART) |-> rd_q && !int_q;
    endproperty
    a_no_wr_rstart: assert property (p_no_wr_rstart) else $error("restart inside a write");

    property p_sda_steady;
        @(posedge ref_clk) disable iff (rst)
            (st_q == ssi_pkg::ST_BIT && $changed(sda_oe_q)) |-> $past(scl_oe_q);
    endproperty
    a_sda_steady: assert property (p_sda_steady) else $error("data moved with clock high");

endmodule : ssi_host

// File: core/ssi_pkg.sv
/*
 * Constants, types and state codes for the two-wire host controller that
 * drives the metering device's serial port. Assumes a 10 MHz reference
 * clock and an open-drain bus with external pull-ups.
 */
package ssi_pkg;

    localparam logic [6:0]  SLAVE_ADDR    = 7'h38;
    localparam logic [15:0] LOCK_REG_ADDR = 16'hEC01;
    localparam int          LOCK_BIT      = 1;
    localparam logic [7:0]  LOCK_VALUE    = 8'h02;
    localparam int          SCL_PERIOD_NS = 2500;
    localparam int          CLK_PERIOD_NS = 100;
    // quarter bit period, rounded up so the rate stays at or below the limit
    localparam int          QTR_CYC       = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                            / (4 * CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_BIT    = 3'b010,
        ST_RSTART = 3'b011,
        ST_STOP   = 3'b100,
        ST_DONE   = 3'b101
    } ssi_state_e;

    typedef enum logic [1:0] {
        RL_ADDR = 2'b00,
        RL_REG  = 2'b01,
        RL_WDAT = 2'b10,
        RL_RDAT = 2'b11
    } ssi_role_e;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [2:0]  nbytes;
    } ssi_cmd_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        nack;
        logic        lost;
    } ssi_rsp_s;

endpackage : ssi_pkg

// File: core/ssi_sync2.sv
/*
 * Two-flop synchroniser for the bus line inputs.
 * Assumes the inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
module ssi_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk,   // sampling clock
    input  wire logic         rst,   // async reset, active high
    input  wire logic [W-1:0] d,     // asynchronous levels
    output logic      [W-1:0] q      // synchronised levels
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '1;
            q      <= '1;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : ssi_sync2

// File: sim/ssi_dev_model.sv
/*
 * Behavioural model of the metering device's two-wire slave port.
 * Assumes the bench resolves both lines as pulled-up wired-AND.
 */
`timescale 1ns/1ps
module ssi_dev_model (
    input  wire logic rst,      // hardware reset, active high
    input  wire logic scl,      // resolved clock line
    input  wire logic sda,      // resolved data line
    input  wire logic sel,      // shared_select_pin
    input  wire logic nack_all, // refuse every byte
    input  wire logic stretch,  // hold clock low before each ack
    output logic      sda_oe,   // pulls data low
    output logic      scl_oe,   // pulls clock low
    output logic      cap_en,   // fast_capture_port enabled
    output logic      two_wire, // two-wire port in use
    output logic      lock_q    // port choice locked
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic [15:0] ptr;
    logic        act;
    logic        rdm;
    int          bcnt;
    int          bidx;
    int          tog;

    initial begin
        {sda_oe, scl_oe, act, rdm, cap_en, lock_q} = 6'h00;
        two_wire = 1'b1;
        tog = 0;
    end
    always @(posedge rst) begin
        cap_en   = 1'b0;
        two_wire = 1'b1;
        lock_q   = 1'b0;
        tog      = 0;
        act      = 1'b0;
    end
    always @(negedge sel) begin
        if (!lock_q && two_wire) begin
            tog = tog + 1;
            if (tog == 3) two_wire = 1'b0;
        end
    end
    // start and stop conditions
    always @(negedge sda) if (scl === 1'b1) begin
        act = two_wire;
        bcnt = 0;
        bidx = 0;
        rdm = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    always @(posedge scl) if (act) begin
        if (bcnt < 8) sh = {sh[6:0], sda};
        else if (rdm && bidx > 0 && sda) act = 1'b0;
        bcnt = bcnt + 1;
    end
    always @(negedge scl) if (act) begin
        if (bcnt == 8 && !(rdm && bidx > 0)) begin
            if (bidx == 0 && sh[7:1] != ssi_pkg::SLAVE_ADDR) act = 1'b0;
            else if (bidx == 0) rdm = sh[0];
            else if (bidx == 1) ptr[15:8] = sh;
            else if (bidx == 2) ptr[7:0] = sh;
            else if (!nack_all) begin
                mem[ptr] = sh;
                if (ptr == ssi_pkg::LOCK_REG_ADDR && sh[ssi_pkg::LOCK_BIT]) lock_q = 1'b1;
                ptr = ptr + 16'h0001;
            end
            if (act && stretch) begin
                scl_oe <= 1'b1;
                scl_oe <= #3000 1'b0;
            end
            sda_oe <= #200 act && !nack_all;
            if (nack_all) act = 1'b0;
        end else if (bcnt == 9) begin
            bcnt = 0;
            bidx = bidx + 1;
            if (rdm) begin
                tx = mem[ptr];
                ptr = ptr + 16'h0001;
            end
            sda_oe <= #200 rdm && !tx[7];
        end else if (rdm && bidx > 0) sda_oe <= #200 (bcnt == 8) ? 1'b0 : !tx[7 - bcnt];
    end
endmodule : ssi_dev_model

// File: sim/testbench.sv
/*
 * Self-checking bench for the two-wire host controller.
 * Assumes the device model and pull-ups on both lines.
 */
`timescale 1ns/1ps
module testbench;
    logic              ref_clk   = 1'b0;
    logic              rst       = 1'b1;
    logic              cmd_valid = 1'b0;
    ssi_pkg::ssi_cmd_s cmd       = '0;
    ssi_pkg::ssi_rsp_s rsp;
    ssi_pkg::ssi_rsp_s got;
    logic              nack_all  = 1'b0;
    logic              stretch   = 1'b0;
    logic              cmd_ready, rsp_valid, locked, sel_pin, scl_drv, scl_oe, sda_drv, sda_oe;
    logic              dev_sda_oe, dev_scl_oe, cap_en, two_wire, dev_lock;
    wire               scl_w     = ~(scl_oe | dev_scl_oe);
    wire               sda_w     = ~(sda_oe | dev_sda_oe);
    int                error_cnt = 0;
    int                cmp_count = 0;
    realtime           last_rise = 0.0;

    always #50 ref_clk = ~ref_clk;

    ssi_host uut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .locked(locked),
        .shared_select_pin(sel_pin), .scl_lvl(scl_w), .scl_drv(scl_drv), .scl_oe(scl_oe),
        .sda_lvl(sda_w), .sda_drv(sda_drv), .sda_oe(sda_oe));
    ssi_dev_model dev (.rst(rst), .scl(scl_w), .sda(sda_w), .sel(sel_pin), .nack_all(nack_all),
        .stretch(stretch), .sda_oe(dev_sda_oe), .scl_oe(dev_scl_oe), .cap_en(cap_en),
        .two_wire(two_wire), .lock_q(dev_lock));

    task automatic cmp_bit(input string nm, input logic exp, input logic act);
        cmp_count++;
        if (act !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, act);
        end
    endtask : cmp_bit
    task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] act);
        cmp_count++;
        if (act !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, act);
        end
    endtask : cmp_word
    task automatic stop_test;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic do_cmd(input logic r, input logic [15:0] a, input logic [31:0] d,
                          input logic [2:0] n);
        int k;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd       <= {r, a, d, n};
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 100);
        cmd_valid <= 1'b0;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (rsp_valid !== 1'b1 && k < 20000);
        cmp_bit("rsp_valid", 1'b1, rsp_valid);
        got = rsp;
    endtask : do_cmd

    task automatic t_reset;
        int k;
        cmp_bit("sel_toggles", 1'b1, dev.tog == 0);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        cmp_bit("cmd_ready_rst", 1'b0, cmd_ready);
        cmp_bit("scl_oe_rst", 1'b0, scl_oe);
        cmp_bit("sda_oe_rst", 1'b0, sda_oe);
        cmp_bit("locked_rst", 1'b0, locked);
        cmp_bit("dev_lock_rst", 1'b0, dev_lock);
        rst <= 1'b0;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 20000);
        cmp_bit("locked", 1'b1, locked);
        cmp_bit("dev_lock", 1'b1, dev_lock);
        cmp_word("lock_reg", {24'h0, ssi_pkg::LOCK_VALUE},
                 {24'h0, dev.mem[ssi_pkg::LOCK_REG_ADDR]});
        cmp_bit("two_wire", 1'b1, two_wire);
        cmp_bit("cap_en", 1'b0, cap_en);
        cmp_bit("sel_pin", 1'b1, sel_pin);
        cmp_bit("scl_drv", 1'b0, scl_drv);
        cmp_bit("sda_drv", 1'b0, sda_drv);
    endtask : t_reset

    task automatic t_wr_rd(input logic [2:0] n, input logic [15:0] a, input logic [31:0] d);
        int i;
        do_cmd(1'b0, a, d, n);
        cmp_bit("wr_nack", 1'b0, got.nack);
        cmp_bit("wr_lost", 1'b0, got.lost);
        for (i = 0; i < n; i++)
            cmp_word("wr_byte", {24'h0, d[8*(n-1-i) +: 8]}, {24'h0, dev.mem[a + i]});
        do_cmd(1'b1, a, 32'h00000000, n);
        cmp_bit("rd_nack", 1'b0, got.nack);
        cmp_bit("rd_lost", 1'b0, got.lost);
        cmp_word("rd_data", d & (32'hFFFFFFFF >> (8 * (4 - n))), got.rdata);
    endtask : t_wr_rd

    task automatic t_stretch;
        stretch <= 1'b1;
        t_wr_rd(3'd2, 16'h4380, 32'h0000BEEF);
        stretch <= 1'b0;
    endtask : t_stretch

    task automatic t_nack;
        nack_all <= 1'b1;
        do_cmd(1'b0, 16'h43A0, 32'h00000055, 3'd1);
        cmp_bit("nack_seen", 1'b1, got.nack);
        cmp_word("nack_mem", 32'h00000012, {24'h0, dev.mem[16'h43A0]});
        nack_all <= 1'b0;
    endtask : t_nack

    // bus clock rate check between rising edges
    always @(posedge scl_w) begin
        if (!rst && last_rise > 0.0)
            cmp_bit("scl_rate", 1'b1, ($realtime - last_rise) >= 2500.0);
        last_rise = $realtime;
    end

    initial begin
        #8000000;
        error_cnt++;
        stop_test();
    end

    initial begin
        t_reset();
        t_wr_rd(3'd4, 16'h43A0, 32'h1234ABCD);
        t_wr_rd(3'd2, 16'h4310, 32'h0000C35A);
        t_wr_rd(3'd1, 16'hE7FE, 32'h000000A7);
        t_stretch();
        t_nack();
        t_reset();
        t_wr_rd(3'd1, 16'h4311, 32'h0000005A);
        stop_test();
    end
endmodule : testbench
